/* core/exec_pkg.sv */
package exec_pkg;
    // Instruction opcodes
    localparam logic [13:0] OPC_IDLE   = 14'h0000;
    localparam logic [13:0] OPC_RETFI  = 14'h0009;
    localparam logic [13:0] OPC_RETSUB = 14'h0008;
    localparam logic [6:0]  OPC_STORE  = 7'h01;
    localparam logic [5:0]  OPC_MOVE   = 6'h08;
    localparam logic [5:0]  OPC_ROTR   = 6'h0C;
    localparam logic [5:0]  OPC_ROTL   = 6'h0D;
    localparam logic [3:0]  OPC_LITRET = 4'hD;
    // Field positions
    localparam int DEST_BIT   = 7;
    localparam int ADDR_MSB   = 6;
    localparam int LIT_MSB    = 7;
    // Reset values and file register depth
    localparam logic [7:0]  ACC_RST  = 8'h00;
    localparam logic [12:0] PC_RST   = 13'h0000;
    localparam logic        IRQ_EN_RST = 1'b0;
    localparam logic [7:0]  FILE_RST = 8'h00;
    localparam int FILE_DEPTH = 128;
endpackage

/* core/file_regs.sv */
`timescale 1ns/100ps
`default_nettype none
module file_regs (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    // Access
    input  wire logic [6:0] addr,
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_data,
    output logic      [7:0] rd_data
);
    logic [7:0] mem [exec_pkg::FILE_DEPTH];
    genvar g;
    generate
        for (g = 0; g < exec_pkg::FILE_DEPTH; g++) begin : g_cell
            always_ff @(posedge ref_clk) begin
                if (!rst_n)
                    mem[g] <= exec_pkg::FILE_RST;
                else if (wr_en && addr == 7'(g))
                    mem[g] <= wr_data;
            end
        end
    endgenerate
    assign rd_data = mem[addr];
endmodule
`default_nettype wire

/* core/move_rotate_return_exec.sv */
// Function
// - store_accumulator_op copies accumulator to file register 0..127, flags unchanged.
// - move_file_op writes file value to accumulator (d=0) or back to file (d=1).
// - move_file_op sets zero flag from the moved value.
// - interrupt_return_op loads program_counter from return_stack_top, sets global_irq_enable.
// - rotate_left_carry_op: carry into bit 0, bit 7 to carry, d selects destination.
// - rotate_right_carry_op: carry into bit 7, bit 0 to carry, d selects destination.
// - literal_return_op loads 8-bit literal to accumulator, program_counter from stack top.
// - literal_return_op takes two cycles and changes no status flag.
// - An instruction discarding its successor holds all state in the next slot, program_counter included.
`timescale 1ns/100ps
`default_nettype none
module move_rotate_return_exec (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // Instruction stream
    input  wire logic [13:0] instr,
    input  wire logic        instr_valid,
    // Return stack
    input  wire logic [12:0] return_stack_top,
    output logic             stack_pop,
    // Architectural state
    output logic [7:0]       accumulator,
    output logic [12:0]      program_counter,
    output logic             carry_flag,
    output logic             zero_flag,
    output logic             global_irq_enable,
    output logic             flush_cycle
);
    typedef struct packed {
        logic [7:0]  acc;
        logic [12:0] pc;
        logic        c;
        logic        z;
        logic        irq_en;
        logic        flush;
        logic        pop;
    } state_t;

    state_t st;
    state_t next_st;
    logic [6:0] faddr;
    logic       fwr;
    logic [7:0] fwdata;
    logic [7:0] frdata;
    logic       dsel;

    assign faddr = instr[exec_pkg::ADDR_MSB:0];
    assign dsel  = instr[exec_pkg::DEST_BIT];

    file_regs file_regs_i (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .addr    (faddr),
        .wr_en   (fwr),
        .wr_data (fwdata),
        .rd_data (frdata)
    );

    always_comb begin
        next_st = st;
        next_st.pop = 1'b0;
        next_st.flush = 1'b0;
        fwr = 1'b0;
        fwdata = frdata;
        if (st.flush) begin
            next_st.pc = st.pc;
        end else if (instr_valid) begin
            next_st.pc = st.pc + 13'h0001;
            if (instr == exec_pkg::OPC_IDLE) begin
                next_st.pc = st.pc + 13'h0001;
            end else if (instr == exec_pkg::OPC_RETFI) begin
                next_st.pc = return_stack_top;
                next_st.irq_en = 1'b1;
                next_st.pop = 1'b1;
                next_st.flush = 1'b1;
            end else if (instr == exec_pkg::OPC_RETSUB) begin
                next_st.pc = return_stack_top;
                next_st.pop = 1'b1;
                next_st.flush = 1'b1;
            end else if (instr[13:7] == exec_pkg::OPC_STORE) begin
                fwr = 1'b1;
                fwdata = st.acc;
            end else if (instr[13:8] == exec_pkg::OPC_MOVE) begin
                next_st.z = (frdata == 8'h00);
                if (dsel)
                    fwr = 1'b1;
                else
                    next_st.acc = frdata;
            end else if (instr[13:8] == exec_pkg::OPC_ROTL) begin
                fwdata = {frdata[6:0], st.c};
                next_st.c = frdata[7];
                if (dsel)
                    fwr = 1'b1;
                else
                    next_st.acc = fwdata;
            end else if (instr[13:8] == exec_pkg::OPC_ROTR) begin
                fwdata = {st.c, frdata[7:1]};
                next_st.c = frdata[0];
                if (dsel)
                    fwr = 1'b1;
                else
                    next_st.acc = fwdata;
            end else if (instr[13:10] == exec_pkg::OPC_LITRET) begin
                next_st.acc = instr[exec_pkg::LIT_MSB:0];
                next_st.pc = return_stack_top;
                next_st.pop = 1'b1;
                next_st.flush = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st <= '{acc: exec_pkg::ACC_RST, pc: exec_pkg::PC_RST, c: 1'b0, z: 1'b0,
                    irq_en: exec_pkg::IRQ_EN_RST, flush: 1'b0, pop: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign accumulator       = st.acc;
    assign program_counter   = st.pc;
    assign carry_flag        = st.c;
    assign zero_flag         = st.z;
    assign global_irq_enable = st.irq_en;
    assign flush_cycle       = st.flush;
    assign stack_pop         = st.pop;

    logic is_store;
    logic is_litret;
    assign is_store  = instr_valid && !st.flush && instr[13:7] == exec_pkg::OPC_STORE;
    assign is_litret = instr_valid && !st.flush && instr[13:10] == exec_pkg::OPC_LITRET;

    property p_store_flags;
        @(posedge ref_clk) disable iff (!rst_n)
        is_store |=> (carry_flag == $past(carry_flag)) && (zero_flag == $past(zero_flag));
    endproperty
    a_store_flags: assert property (p_store_flags) else $error("store changed flags");

    property p_move_acc;
        @(posedge ref_clk) disable iff (!rst_n)
        (instr_valid && !st.flush && instr[13:8] == exec_pkg::OPC_MOVE && !dsel)
        |=> accumulator == $past(frdata);
    endproperty
    a_move_acc: assert property (p_move_acc) else $error("move to accumulator wrong");

    property p_move_zero;
        @(posedge ref_clk) disable iff (!rst_n)
        (instr_valid && !st.flush && instr[13:8] == exec_pkg::OPC_MOVE)
        |=> zero_flag == ($past(frdata) == 8'h00);
    endproperty
    a_move_zero: assert property (p_move_zero) else $error("zero flag wrong");

    property p_irq_return;
        @(posedge ref_clk) disable iff (!rst_n)
        (instr_valid && !st.flush && instr == exec_pkg::OPC_RETFI)
        |=> global_irq_enable && program_counter == $past(return_stack_top) && flush_cycle;
    endproperty
    a_irq_return: assert property (p_irq_return) else $error("interrupt return wrong");

    property p_rotl;
        @(posedge ref_clk) disable iff (!rst_n)
        (instr_valid && !st.flush && instr[13:8] == exec_pkg::OPC_ROTL)
        |=> carry_flag == $past(frdata[7]);
    endproperty
    a_rotl: assert property (p_rotl) else $error("rotate left carry wrong");

    property p_rotr;
        @(posedge ref_clk) disable iff (!rst_n)
        (instr_valid && !st.flush && instr[13:8] == exec_pkg::OPC_ROTR)
        |=> carry_flag == $past(frdata[0]);
    endproperty
    a_rotr: assert property (p_rotr) else $error("rotate right carry wrong");

    property p_litret;
        @(posedge ref_clk) disable iff (!rst_n)
        is_litret |=> accumulator == $past(instr[7:0]) && program_counter == $past(return_stack_top);
    endproperty
    a_litret: assert property (p_litret) else $error("literal return wrong");

    property p_litret_two;
        @(posedge ref_clk) disable iff (!rst_n)
        is_litret |=> flush_cycle ##1 (!flush_cycle && $stable(program_counter) && $stable(carry_flag));
    endproperty
    a_litret_two: assert property (p_litret_two) else $error("literal return not two cycles");

    property p_flush_hold;
        @(posedge ref_clk) disable iff (!rst_n)
        flush_cycle |=> $stable(accumulator) && $stable(zero_flag) && $stable(carry_flag)
                        && $stable(program_counter) && !flush_cycle && !stack_pop;
    endproperty
    a_flush_hold: assert property (p_flush_hold) else $error("discarded slot changed state");

    property p_idle;
        @(posedge ref_clk) disable iff (!rst_n)
        (instr_valid && !st.flush && instr == exec_pkg::OPC_IDLE)
        |=> program_counter == $past(program_counter) + 13'h0001 && $stable(accumulator) && !stack_pop
            && $stable(carry_flag) && $stable(zero_flag) && !flush_cycle;
    endproperty
    a_idle: assert property (p_idle) else $error("idle instruction changed state");

    property p_irq_flags;
        @(posedge ref_clk) disable iff (!rst_n)
        (instr_valid && !st.flush && instr == exec_pkg::OPC_RETFI)
        |=> $stable(carry_flag) && $stable(zero_flag) && $stable(accumulator) && stack_pop;
    endproperty
    a_irq_flags: assert property (p_irq_flags) else $error("interrupt return changed flags");

    property p_litret_flags;
        @(posedge ref_clk) disable iff (!rst_n)
        is_litret |=> $stable(carry_flag) && $stable(zero_flag) && $stable(global_irq_enable) && stack_pop;
    endproperty
    a_litret_flags: assert property (p_litret_flags) else $error("literal return changed flags");

    property p_sub_return;
        @(posedge ref_clk) disable iff (!rst_n)
        (instr_valid && !st.flush && instr == exec_pkg::OPC_RETSUB)
        |=> program_counter == $past(return_stack_top) && flush_cycle && $stable(global_irq_enable);
    endproperty
    a_sub_return: assert property (p_sub_return) else $error("subroutine return wrong");

    c_litret: cover property (@(posedge ref_clk) disable iff (!rst_n) is_litret);
    c_discard: cover property (@(posedge ref_clk) disable iff (!rst_n) instr_valid && st.flush);
    c_irq: cover property (@(posedge ref_clk) disable iff (!rst_n) global_irq_enable);
    c_store: cover property (@(posedge ref_clk) disable iff (!rst_n) is_store);
endmodule
`default_nettype wire

/* bench/move_rotate_return_exec_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module move_rotate_return_exec_tb;
    logic        ref_clk          = 1'b0;
    logic        rst_n            = 1'b0;
    logic [13:0] instr            = 14'h0000;
    logic        instr_valid      = 1'b0;
    logic [12:0] return_stack_top = 13'h0000;
    logic        stack_pop;
    logic [7:0]  accumulator;
    logic [12:0] program_counter;
    logic        carry_flag;
    logic        zero_flag;
    logic        global_irq_enable;
    logic        flush_cycle;
    int          errors           = 0;
    int          checks_done      = 0;

    always #2.5 ref_clk = ~ref_clk;

    move_rotate_return_exec move_rotate_return_exec_i (
        .ref_clk           (ref_clk),
        .rst_n             (rst_n),
        .instr             (instr),
        .instr_valid       (instr_valid),
        .return_stack_top  (return_stack_top),
        .stack_pop         (stack_pop),
        .accumulator       (accumulator),
        .program_counter   (program_counter),
        .carry_flag        (carry_flag),
        .zero_flag         (zero_flag),
        .global_irq_enable (global_irq_enable),
        .flush_cycle       (flush_cycle)
    );

    task automatic chk(input string name, input logic [12:0] seen, input logic [12:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // File-register operation word
    function automatic logic [13:0] fo(input logic [5:0] opc, input logic d, input logic [6:0] f);
        return {opc, d, f};
    endfunction

    // Issue one word at a rising edge; returns at the edge that takes it
    task automatic op(input logic [13:0] word);
        instr       <= word;
        instr_valid <= 1'b1;
        @(posedge ref_clk);
        instr_valid <= 1'b0;
    endtask

    // Issue two words back to back; the second meets the discarded slot
    task automatic op_pair(input logic [13:0] first, input logic [13:0] second);
        instr       <= first;
        instr_valid <= 1'b1;
        @(posedge ref_clk);
        instr       <= second;
        @(posedge ref_clk);
        instr_valid <= 1'b0;
    endtask

    // Compare state after the taking edge, then move to the next edge
    task automatic st(input logic [7:0] a, input logic [12:0] p, input logic c, input logic z);
        #1;
        chk("accumulator", {5'h00, accumulator}, {5'h00, a});
        chk("program_counter", program_counter, p);
        chk("carry_flag", {12'h000, carry_flag}, {12'h000, c});
        chk("zero_flag", {12'h000, zero_flag}, {12'h000, z});
        @(posedge ref_clk);
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        #2500;
        errors++;
        end_sim();
    end

    initial begin
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        #1;
        chk("global_irq_enable", {12'h000, global_irq_enable}, 13'h0000);
        chk("stack_pop", {12'h000, stack_pop}, 13'h0000);
        st(8'h00, 13'h0000, 1'b0, 1'b0);
        $display("test reset done");
        return_stack_top <= 13'h0123;
        op_pair({exec_pkg::OPC_LITRET, 2'b00, 8'hA5}, {exec_pkg::OPC_STORE, 7'h03});
        st(8'hA5, 13'h0123, 1'b0, 1'b0);
        op({exec_pkg::OPC_STORE, 7'h7F});
        st(8'hA5, 13'h0124, 1'b0, 1'b0);
        return_stack_top <= 13'h0200;
        op({exec_pkg::OPC_LITRET, 2'b00, 8'h00});
        #1;
        chk("stack_pop", {12'h000, stack_pop}, 13'h0001);
        chk("flush_cycle", {12'h000, flush_cycle}, 13'h0001);
        st(8'h00, 13'h0200, 1'b0, 1'b0);
        $display("test literal return done");
        op(exec_pkg::OPC_IDLE);
        #1;
        chk("stack_pop", {12'h000, stack_pop}, 13'h0000);
        chk("flush_cycle", {12'h000, flush_cycle}, 13'h0000);
        st(8'h00, 13'h0201, 1'b0, 1'b0);
        op(fo(exec_pkg::OPC_MOVE, 1'b0, 7'h7F));
        st(8'hA5, 13'h0202, 1'b0, 1'b0);
        op(fo(exec_pkg::OPC_MOVE, 1'b1, 7'h03));
        st(8'hA5, 13'h0203, 1'b0, 1'b1);
        $display("test move done");
        op(fo(exec_pkg::OPC_ROTL, 1'b0, 7'h7F));
        st(8'h4A, 13'h0204, 1'b1, 1'b1);
        op(fo(exec_pkg::OPC_ROTL, 1'b1, 7'h7F));
        st(8'h4A, 13'h0205, 1'b1, 1'b1);
        op(fo(exec_pkg::OPC_ROTR, 1'b0, 7'h03));
        st(8'h80, 13'h0206, 1'b0, 1'b1);
        op(fo(exec_pkg::OPC_ROTR, 1'b1, 7'h7F));
        st(8'h80, 13'h0207, 1'b1, 1'b1);
        op(fo(exec_pkg::OPC_MOVE, 1'b0, 7'h7F));
        st(8'h25, 13'h0208, 1'b1, 1'b0);
        $display("test rotate done");
        return_stack_top <= 13'h1FFF;
        op(exec_pkg::OPC_RETFI);
        #1;
        chk("global_irq_enable", {12'h000, global_irq_enable}, 13'h0001);
        st(8'h25, 13'h1FFF, 1'b1, 1'b0);
        $display("test interrupt return done");
        return_stack_top <= 13'h0456;
        op(exec_pkg::OPC_RETSUB);
        #1;
        chk("stack_pop", {12'h000, stack_pop}, 13'h0001);
        chk("flush_cycle", {12'h000, flush_cycle}, 13'h0001);
        chk("global_irq_enable", {12'h000, global_irq_enable}, 13'h0001);
        st(8'h25, 13'h0456, 1'b1, 1'b0);
        op(exec_pkg::OPC_IDLE);
        st(8'h25, 13'h0457, 1'b1, 1'b0);
        $display("test subroutine return done");
        end_sim();
    end
endmodule
`default_nettype wire
